// ---- core/rpfc_top.sv ----
// rail phase add/drop, restart, alert and fault parameter capture
// Functional notes
// - every rail phase that has not failed counts as active until power-good is reached
// - phase removal requests are taken only after power-good
// - one write drops or re-adds any member, reference included
// - lowest active member position becomes the reference
// - phase slot follows rank among active members, recomputed on any change
// - after a rail shutdown all members restart together once faults clear
// - alert line pulled low while any reported fault is pending
// - input/output voltage, current, temperatures, frequency, duty readable
// - capture works only when its configuration bit is one
// - captured data returned as one block read, count byte first
// - control value 1 copies stored capture from flash to RAM
// - control value 2 saves capture to flash, only while disabled
// - a shutdown-response fault writes the capture to flash automatically
// - a retry-response fault never writes flash
// - flash write busy lasts 700 us to 1400 us
// - non-volatile store checked at start-up before operation
// - restriction allows restoring defaults but blocks factory restore
// - lowest configured position is reference at start-up, others members
// - a failed member drops out and the rest keep regulating
`timescale 1ns/10ps
`default_nettype none
`include "rpfc_defs.svh"
module rpfc_top #(
	parameter int P_FLASH_MIN_CYC = `RPFC_FLASH_MIN_US * `RPFC_CLK_MHZ,
	parameter int P_FLASH_MAX_CYC = `RPFC_FLASH_MAX_US * `RPFC_CLK_MHZ
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// rail pins
	input wire logic i_pgood,
	input wire logic [3:0] i_fault,
	input wire logic i_rail_fault,
	input wire logic [7:0] i_peer_fail,
	// monitor values, same clock
	input wire logic [7:0] i_mon_vin,
	input wire logic [7:0] i_mon_vout,
	input wire logic [7:0] i_mon_iout,
	input wire logic [7:0] i_mon_tint,
	input wire logic [7:0] i_mon_text,
	input wire logic [7:0] i_mon_fsw,
	input wire logic [7:0] i_mon_duty,
	// open-drain alert line
	input wire logic i_alert_line_n,
	output logic o_alert_line_n_out,
	output logic o_alert_line_n_oe_n,
	// rail control outputs
	output logic o_run,
	output logic o_is_reference,
	output logic [2:0] o_ref_position,
	output logic [2:0] o_phase_slot,
	output logic [3:0] o_active_count,
	output logic o_fault_broadcast,
	output logic o_nvm_ready,
	output logic o_flash_busy,
	output logic o_restore_default,
	output logic o_restore_factory
);
	// lowest set position of a member map
	function automatic logic [2:0] low_pos(input logic [7:0] m);
		low_pos = 3'h0;
		for (int k = 7; k >= 0; k--) begin
			if (m[k]) low_pos = 3'(k);
		end
	endfunction
	// count of set members below a limit
	function automatic logic [3:0] ones_below(input logic [7:0] m, input logic [3:0] lim);
		ones_below = 4'h0;
		for (int k = 0; k < 8; k++) begin
			if (m[k] && (4'(k) < lim)) ones_below = ones_below + 4'h1;
		end
	endfunction

	// reset release through two flops
	logic rst_q, rst_n;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q <= 1'b1;
			rst_n <= rst_q;
		end
	end

	// pin synchronisers
	logic [14:0] pin_a, pin_s;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_a <= 15'h0001;
			pin_s <= 15'h0001;
		end else begin
			pin_a <= {i_peer_fail, i_rail_fault, i_fault, i_pgood, i_alert_line_n};
			pin_s <= pin_a;
		end
	end
	wire alert_in_s = pin_s[0];
	wire pgood_s = pin_s[1];
	wire [3:0] fault_s = pin_s[5:2];
	wire rail_fault_s = pin_s[6];
	wire [7:0] peer_fail_s = pin_s[14:7];

	// register decode
	wire wr_ctrl = i_reg_wr && (i_reg_addr == `RPFC_A_CTRL);
	wire wr_pos = i_reg_wr && (i_reg_addr == `RPFC_A_POS);
	wire wr_rail = i_reg_wr && (i_reg_addr == `RPFC_A_RAIL);
	wire wr_drop = i_reg_wr && (i_reg_addr == `RPFC_A_DROP);
	wire wr_fresp = i_reg_wr && (i_reg_addr == `RPFC_A_FRESP);
	wire wr_frep = i_reg_wr && (i_reg_addr == `RPFC_A_FREP);
	wire wr_capctl = i_reg_wr && (i_reg_addr == `RPFC_A_CAPCTL);
	wire wr_fclr = i_reg_wr && (i_reg_addr == `RPFC_A_FCLR);
	wire wr_restore = i_reg_wr && (i_reg_addr == `RPFC_A_RESTORE);
	wire rd_capdat = i_reg_rd && (i_reg_addr == `RPFC_A_CAPDAT);

	// configuration registers
	logic [7:0] ctrl, rail_map, drop;
	logic [2:0] my_pos;
	logic [3:0] fresp, frep;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `RPFC_RST_CTRL;
			my_pos <= `RPFC_RST_POS;
			rail_map <= `RPFC_RST_RAIL;
			drop <= 8'h00;
			fresp <= `RPFC_RST_FRESP;
			frep <= `RPFC_RST_FREP;
		end else begin
			if (wr_ctrl) ctrl <= i_reg_wdata;
			if (wr_pos) my_pos <= i_reg_wdata[2:0];
			if (wr_rail) rail_map <= i_reg_wdata;
			if (wr_drop && pgood_s) drop <= i_reg_wdata;
			if (wr_fresp) fresp <= i_reg_wdata[3:0];
			if (wr_frep) frep <= i_reg_wdata[3:0];
		end
	end
	wire en = ctrl[`RPFC_CTRL_EN];
	wire cap_en = ctrl[`RPFC_CTRL_CAP];

	// active member set and phase placement
	wire [7:0] rail_live = rail_map & ~peer_fail_s;
	wire [7:0] active = pgood_s ? (rail_live & ~drop) : rail_live;
	wire [2:0] ref_pos = low_pos(active);
	wire [3:0] rank = ones_below(active, {1'b0, my_pos});
	wire [3:0] act_cnt = ones_below(active, 4'h8);
	wire self_active = active[my_pos];

	// fault classes: shutdown or retry response
	wire [3:0] fault_sd = fault_s & fresp;
	wire [3:0] fault_rt = fault_s & ~fresp;
	wire any_sd = |fault_sd;

	// main state: start-up check, run, shutdown
	rpfc_pkg::rpfc_state_e state, next_state;
	logic [3:0] init_cnt;
	always_comb begin
		next_state = state;
		unique case (state)
			rpfc_pkg::RPFC_INIT: if (init_cnt == `RPFC_NVM_CHECK_CYC) next_state = rpfc_pkg::RPFC_RUN;
			rpfc_pkg::RPFC_RUN: if (any_sd || rail_fault_s) next_state = rpfc_pkg::RPFC_SHUT;
			rpfc_pkg::RPFC_SHUT: if (!(|fault_s) && !rail_fault_s) next_state = rpfc_pkg::RPFC_RUN;
			default: next_state = rpfc_pkg::RPFC_INIT;
		endcase
	end

	// state, placement and drive outputs
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= rpfc_pkg::RPFC_INIT;
			init_cnt <= 4'h0;
			o_ref_position <= 3'h0;
			o_is_reference <= 1'b0;
			o_phase_slot <= 3'h0;
			o_active_count <= 4'h0;
			o_run <= 1'b0;
			o_fault_broadcast <= 1'b0;
		end else begin
			state <= next_state;
			if (state == rpfc_pkg::RPFC_INIT) init_cnt <= init_cnt + 4'h1;
			o_ref_position <= ref_pos;
			o_is_reference <= self_active && (ref_pos == my_pos);
			o_phase_slot <= rank[2:0];
			o_active_count <= act_cnt;
			o_run <= (next_state == rpfc_pkg::RPFC_RUN) && en && self_active && !(|fault_rt);
			o_fault_broadcast <= (next_state == rpfc_pkg::RPFC_SHUT);
		end
	end
	assign o_nvm_ready = (state != rpfc_pkg::RPFC_INIT);

	// sticky fault flags; a new fault wins over a clear
	logic [3:0] fsticky;
	wire [3:0] next_fsticky = (fsticky & ~(wr_fclr ? i_reg_wdata[3:0] : 4'h0)) | fault_s;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fsticky <= 4'h0;
			o_alert_line_n_oe_n <= 1'b1;
		end else begin
			fsticky <= next_fsticky;
			o_alert_line_n_oe_n <= !(|(fsticky & frep));
		end
	end
	assign o_alert_line_n_out = 1'b0;

	// capture RAM, flash image and write timer
	logic [7:0] snap [`RPFC_SNAP_BYTES];
	logic [7:0] flash [`RPFC_SNAP_BYTES];
	logic [15:0] busy_cnt;
	logic any_sd_q;
	logic [3:0] blk_ptr;
	wire [7:0] status = {o_flash_busy, 1'b0, !o_alert_line_n_oe_n, o_fault_broadcast,
		o_is_reference, o_nvm_ready, alert_in_s, pgood_s};
	wire [7:0] live [`RPFC_SNAP_BYTES];
	assign live[0] = status;
	assign live[1] = i_mon_vin;
	assign live[2] = i_mon_vout;
	assign live[3] = i_mon_iout;
	assign live[4] = i_mon_tint;
	assign live[5] = i_mon_text;
	assign live[6] = i_mon_fsw;
	assign live[7] = i_mon_duty;
	wire sd_rise = any_sd && !any_sd_q;
	wire auto_wr = sd_rise && cap_en && !o_flash_busy;
	wire cmd_store = wr_capctl && (i_reg_wdata == `RPFC_CAP_STORE) && !en && cap_en && !o_flash_busy;
	wire cmd_load = wr_capctl && (i_reg_wdata == `RPFC_CAP_LOAD) && cap_en && !o_flash_busy;
	wire start_wr = auto_wr || cmd_store;
	wire [15:0] wr_len = ctrl[`RPFC_CTRL_BLOCK] ? 16'(P_FLASH_MIN_CYC) : 16'(P_FLASH_MAX_CYC);
	assign o_flash_busy = (busy_cnt != 16'h0000);

	// capture and flash transfers
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 16'h0000;
			any_sd_q <= 1'b0;
			for (int k = 0; k < `RPFC_SNAP_BYTES; k++) begin
				snap[k] <= 8'h00;
				flash[k] <= 8'h00;
			end
		end else begin
			any_sd_q <= any_sd;
			if (start_wr) busy_cnt <= wr_len;
			else if (o_flash_busy) busy_cnt <= busy_cnt - 16'h0001;
			for (int k = 0; k < `RPFC_SNAP_BYTES; k++) begin
				if (auto_wr) snap[k] <= live[k];
				else if (cmd_load) snap[k] <= flash[k];
				if (busy_cnt == 16'h0001) flash[k] <= snap[k];
			end
		end
	end

	// block read pointer: count byte, then the captured bytes
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) blk_ptr <= 4'h0;
		else if (wr_capctl) blk_ptr <= 4'h0;
		else if (rd_capdat) blk_ptr <= (blk_ptr == 4'(`RPFC_SNAP_BYTES)) ? 4'h0 : blk_ptr + 4'h1;
	end
	wire [7:0] blk_byte = (blk_ptr == 4'h0) ? 8'(`RPFC_SNAP_BYTES) : snap[3'(blk_ptr - 4'h1)];

	// restore commands with restriction
	logic restore_blocked;
	wire rq_def = wr_restore && (i_reg_wdata == `RPFC_RESTORE_DEF);
	wire rq_fact = wr_restore && (i_reg_wdata == `RPFC_RESTORE_FACT);
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_restore_default <= 1'b0;
			o_restore_factory <= 1'b0;
			restore_blocked <= 1'b0;
		end else begin
			o_restore_default <= rq_def;
			o_restore_factory <= rq_fact && !ctrl[`RPFC_CTRL_RESTRICT];
			restore_blocked <= (restore_blocked && !rq_def) || (rq_fact && ctrl[`RPFC_CTRL_RESTRICT]);
		end
	end

	// read selection, monitors included
	wire [7:0] mon_off = i_reg_addr - `RPFC_A_MON;
	wire mon_hit = (i_reg_addr >= `RPFC_A_MON) && (mon_off[1:0] == 2'b00) && (mon_off[7:2] < 6'(`RPFC_MON_N));
	wire [2:0] mon_idx = 3'(mon_off[7:2] + 6'h01);
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (mon_hit) rd_mux = live[mon_idx];
		else begin
			unique case (i_reg_addr)
				`RPFC_A_CTRL: rd_mux = ctrl;
				`RPFC_A_POS: rd_mux = {5'h00, my_pos};
				`RPFC_A_RAIL: rd_mux = rail_map;
				`RPFC_A_DROP: rd_mux = drop;
				`RPFC_A_FRESP: rd_mux = {4'h0, fresp};
				`RPFC_A_FREP: rd_mux = {4'h0, frep};
				`RPFC_A_CAPCTL: rd_mux = {7'h00, o_flash_busy};
				`RPFC_A_CAPDAT: rd_mux = blk_byte;
				`RPFC_A_STAT: rd_mux = {status[7], restore_blocked, status[5:0]};
				`RPFC_A_FCLR: rd_mux = {4'h0, fsticky};
				default: rd_mux = 8'h00;
			endcase
		end
	end
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) o_reg_rdata <= 8'h00;
		else o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
	end

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] busy_len;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) busy_len <= 16'h0000;
		else busy_len <= o_flash_busy ? busy_len + 16'h0001 : 16'h0000;
	end
	sequence s_rail_clear;
		state == rpfc_pkg::RPFC_SHUT && !(|fault_s) && !rail_fault_s;
	endsequence
	a_prepg_all_active: assert property (!pgood_s |-> active == rail_live) else $error("phase inactive before power-good");
	a_early_drop_ignored: assert property (wr_drop && !pgood_s |=> $stable(drop)) else $error("drop taken before power-good");
	a_ref_first_slot: assert property (o_is_reference |-> o_phase_slot == 3'h0) else $error("reference not in slot zero");
	a_slot_in_range: assert property (o_is_reference || o_run |-> {1'b0, o_phase_slot} < o_active_count) else $error("slot out of range");
	a_rail_restart: assert property (s_rail_clear |=> state == rpfc_pkg::RPFC_RUN) else $error("restart missed");
	a_alert_drive: assert property (|(fsticky & frep) |=> !o_alert_line_n_oe_n) else $error("alert not driven");
	a_capture_gated: assert property ($rose(o_flash_busy) |-> $past(cap_en)) else $error("flash write with capture off");
	a_store_disabled: assert property (start_wr && !sd_rise |-> !en) else $error("store while enabled");
	a_retry_no_flash: assert property (!(|fault_sd) && !o_flash_busy && !wr_capctl |=> !o_flash_busy) else $error("retry fault wrote flash");
	a_flash_time: assert property ($fell(o_flash_busy) |-> busy_len >= 16'(P_FLASH_MIN_CYC) && busy_len <= 16'(P_FLASH_MAX_CYC)) else $error("flash time out of bounds");
	a_factory_blocked: assert property (rq_fact && ctrl[`RPFC_CTRL_RESTRICT] |=> !o_restore_factory ##0 restore_blocked) else $error("factory restore not blocked");
endmodule
`default_nettype wire

// ---- core/rpfc_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef RPFC_DEFS_SVH
`define RPFC_DEFS_SVH
`define RPFC_A_CTRL 8'h00
`define RPFC_A_POS 8'h04
`define RPFC_A_RAIL 8'h08
`define RPFC_A_DROP 8'h0C
`define RPFC_A_FRESP 8'h10
`define RPFC_A_FREP 8'h14
`define RPFC_A_CAPCTL 8'h18
`define RPFC_A_CAPDAT 8'h1C
`define RPFC_A_STAT 8'h20
`define RPFC_A_FCLR 8'h24
`define RPFC_A_RESTORE 8'h28
`define RPFC_A_MON 8'h30
`define RPFC_MON_N 7
`define RPFC_CTRL_EN 0
`define RPFC_CTRL_CAP 1
`define RPFC_CTRL_RESTRICT 2
`define RPFC_CTRL_BLOCK 3
`define RPFC_RST_CTRL 8'h00
`define RPFC_RST_POS 3'h0
`define RPFC_RST_RAIL 8'h01
`define RPFC_RST_FRESP 4'hF
`define RPFC_RST_FREP 4'hF
`define RPFC_CAP_LOAD 8'h01
`define RPFC_CAP_STORE 8'h02
`define RPFC_RESTORE_DEF 8'h01
`define RPFC_RESTORE_FACT 8'h02
`define RPFC_SNAP_BYTES 8
`define RPFC_CLK_MHZ 25
`define RPFC_FLASH_MIN_US 700
`define RPFC_FLASH_MAX_US 1400
`define RPFC_NVM_CHECK_CYC 4'hF
`endif

// ---- core/rpfc_pkg.sv ----
// types shared by the rail phase and fault capture block
package rpfc_pkg;
	typedef enum logic [1:0] {
		RPFC_INIT = 2'b00,
		RPFC_RUN = 2'b01,
		RPFC_SHUT = 2'b10
	} rpfc_state_e;
	typedef logic [7:0] rpfc_byte_t;
endpackage

// ---- dv/rpfc_host_model.sv ----
// host side model: alert wire pull-up and alert response polling
`timescale 1ns/10ps
`default_nettype none
module rpfc_host_model (
	// clock
	input wire logic i_clk,
	// alert wire parties
	input wire logic i_dev_out,
	input wire logic i_dev_oe_n,
	input wire logic i_peer_pull,
	// resolved wire and poll count
	output logic o_alert_wire,
	output int o_ara_count
);
	logic [2:0] tick = 3'h0;
	int ara_q = 0;
	// pull-up unless a party pulls low
	assign o_alert_wire = !((!i_dev_oe_n && !i_dev_out) || i_peer_pull);
	assign o_ara_count = ara_q;
	// alert response transfer every 8 cycles while the wire stays low
	always @(posedge i_clk) begin
		tick <= tick + 3'h1;
		if (!o_alert_wire && tick == 3'h7) begin
			ara_q <= ara_q + 1;
		end
	end
endmodule
`default_nettype wire

// ---- dv/rpfc_tb_top.sv ----
// self-checking bench for rail phase and fault capture
`timescale 1ns/10ps
`default_nettype none
`include "rpfc_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module rpfc_tb_top;
	logic clk, rst_b, wr, rd, pgood, rail_f, peer_pull, alert_w, a_out, oe_n;
	logic run, is_ref, bcast, nvm, busy, rdef, rfact;
	logic [7:0] addr, wdata, rdata, peer_fail, rv, act;
	logic [7:0] mon [7];
	logic [7:0] snap [7];
	logic [3:0] fault, cnt;
	logic [2:0] pos, ref_pos, slot;
	logic [9:0] exp_r;
	int fails, checks, ara, ndef, nfact, n;
	rpfc_top #(.P_FLASH_MIN_CYC(20), .P_FLASH_MAX_CYC(40)) rpfc_top_i (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_pgood(pgood), .i_fault(fault),
		.i_rail_fault(rail_f), .i_peer_fail(peer_fail), .i_mon_vin(mon[0]), .i_mon_vout(mon[1]),
		.i_mon_iout(mon[2]), .i_mon_tint(mon[3]), .i_mon_text(mon[4]), .i_mon_fsw(mon[5]),
		.i_mon_duty(mon[6]), .i_alert_line_n(alert_w), .o_alert_line_n_out(a_out),
		.o_alert_line_n_oe_n(oe_n), .o_run(run), .o_is_reference(is_ref), .o_ref_position(ref_pos),
		.o_phase_slot(slot), .o_active_count(cnt), .o_fault_broadcast(bcast), .o_nvm_ready(nvm),
		.o_flash_busy(busy), .o_restore_default(rdef), .o_restore_factory(rfact));
	rpfc_host_model rpfc_host_model_i (.i_clk(clk), .i_dev_out(a_out), .i_dev_oe_n(oe_n),
		.i_peer_pull(peer_pull), .o_alert_wire(alert_w), .o_ara_count(ara));
	// clock
	always #20 clk = ~clk;
	// restore pulse counters
	always @(posedge clk) begin
		if (rdef === 1'b1) ndef++;
		if (rfact === 1'b1) nfact++;
	end
	// expected {reference, slot, count} from the active bitmap
	function automatic logic [9:0] rail_exp(input logic [7:0] a, input logic [2:0] p);
		logic [2:0] r;
		logic [2:0] s;
		logic [3:0] c;
		r = 3'h0;
		s = 3'h0;
		c = 4'h0;
		for (int i = 7; i >= 0; i--) if (a[i]) r = 3'(i);
		for (int i = 0; i < 8; i++) begin
			if (a[i]) c++;
			if (a[i] && i < p) s++;
		end
		return {r, s, c};
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic settle;
		repeat (6) @(posedge clk);
	endtask
	task automatic check_rail;
		exp_r = rail_exp(act, pos);
		`CHK({ref_pos, slot, cnt}, exp_r)
		`CHK(is_ref, exp_r[9:7] == pos)
	endtask
	// length of one flash busy interval
	// counts the cycles in which busy stands, looked at just after each edge
	task automatic busy_len(input int e);
		#1;
		for (int i = 0; i < 10 && busy !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
			#1;
		end
		`CHK(n, e)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (8000) @(posedge clk);
		fails++;
		tally_and_finish;
	end
	// main sequence
	initial begin
		clk = 0; rst_b = 0; wr = 0; rd = 0; addr = 0; wdata = 0; pgood = 0; fault = 0;
		rail_f = 0; peer_fail = 0; peer_pull = 0; fails = 0; checks = 0; ndef = 0; nfact = 0;
		void'($urandom(74099));
		foreach (mon[k]) mon[k] = 8'($urandom);
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK(nvm, 1'b0)
		repeat (20) @(posedge clk);
		`CHK(nvm, 1'b1)
		rd_reg(`RPFC_A_RAIL);
		`CHK(rv, `RPFC_RST_RAIL)
		rd_reg(`RPFC_A_FRESP);
		`CHK(rv, 8'h0F)
		rd_reg(8'hFC);
		`CHK(rv, 8'h00)
		// four members, early drop ignored
		pos = 3'($urandom_range(1, 3));
		act = 8'h0F;
		wr_reg(`RPFC_A_RAIL, act);
		wr_reg(`RPFC_A_POS, {5'h00, pos});
		wr_reg(`RPFC_A_CTRL, 8'h01);
		wr_reg(`RPFC_A_DROP, 8'h01);
		settle;
		check_rail;
		pgood <= 1'b1;
		settle;
		// drop the reference, then random drops
		act = 8'h0E;
		wr_reg(`RPFC_A_DROP, 8'h01);
		settle;
		check_rail;
		repeat (6) begin
			rv = 8'($urandom) & 8'h0F & ~(8'h01 << pos);
			act = 8'h0F & ~rv;
			wr_reg(`RPFC_A_DROP, rv);
			settle;
			check_rail;
		end
		act = 8'h0F;
		wr_reg(`RPFC_A_DROP, 8'h00);
		settle;
		check_rail;
		peer_fail <= 8'h01;
		act = 8'h0E;
		settle;
		check_rail;
		`CHK(run, 1'b1)
		peer_fail <= 8'h00;
		// retry fault: alert, no flash write
		wr_reg(`RPFC_A_FRESP, 8'h0D);
		wr_reg(`RPFC_A_CTRL, 8'h03);
		fault <= 4'h2;
		settle;
		`CHK(oe_n, 1'b0)
		`CHK(busy, 1'b0)
		`CHK(bcast, 1'b0)
		repeat (20) @(posedge clk);
		`CHK(ara > 1, 1'b1)
		fault <= 4'h0;
		// let the cleared fault reach the flags before the clear, or the set wins
		settle;
		wr_reg(`RPFC_A_FCLR, 8'h0F);
		settle;
		`CHK(oe_n, 1'b1)
		`CHK(a_out, 1'b0)
		`CHK(run, 1'b1)
		// another device holds the alert wire: host keeps polling, then stops
		peer_pull <= 1'b1;
		n = ara;
		repeat (20) @(posedge clk);
		`CHK(ara > n, 1'b1)
		rd_reg(`RPFC_A_STAT);
		`CHK(rv[1], 1'b0)
		peer_pull <= 1'b0;
		repeat (4) @(posedge clk);
		n = ara;
		repeat (20) @(posedge clk);
		`CHK(ara, n)
		// shutdown with capture off, rail fault
		wr_reg(`RPFC_A_FRESP, 8'h0F);
		wr_reg(`RPFC_A_CTRL, 8'h01);
		rail_f <= 1'b1;
		fault <= 4'h1;
		settle;
		`CHK({run, bcast, busy}, 3'b010)
		rail_f <= 1'b0;
		fault <= 4'h0;
		settle;
		`CHK({run, bcast}, 2'b10)
		// shutdown with capture on
		wr_reg(`RPFC_A_CTRL, 8'h03);
		snap = mon;
		fault <= 4'h4;
		busy_len(40);
		fault <= 4'h0;
		foreach (mon[k]) mon[k] <= 8'($urandom);
		wr_reg(`RPFC_A_FCLR, 8'h0F);
		wr_reg(`RPFC_A_CAPCTL, `RPFC_CAP_LOAD);
		settle;
		rd_reg(`RPFC_A_CAPDAT);
		`CHK(rv, 8'h08)
		rd_reg(`RPFC_A_CAPDAT);
		for (int k = 0; k < 7; k++) begin
			rd_reg(`RPFC_A_CAPDAT);
			`CHK(rv, snap[k])
		end
		for (int k = 0; k < 7; k++) begin
			rd_reg(8'(`RPFC_A_MON + 4 * k));
			`CHK(rv, mon[k])
		end
		// store refused while enabled, then block-write store
		wr_reg(`RPFC_A_CTRL, 8'h0B);
		wr_reg(`RPFC_A_CAPCTL, `RPFC_CAP_STORE);
		settle;
		`CHK(busy, 1'b0)
		wr_reg(`RPFC_A_CTRL, 8'h0A);
		wr_reg(`RPFC_A_CAPCTL, `RPFC_CAP_STORE);
		busy_len(20);
		// restricted restores
		wr_reg(`RPFC_A_CTRL, 8'h04);
		wr_reg(`RPFC_A_RESTORE, `RPFC_RESTORE_FACT);
		wr_reg(`RPFC_A_RESTORE, `RPFC_RESTORE_DEF);
		settle;
		`CHK(nfact, 0)
		`CHK(ndef, 1)
		wr_reg(`RPFC_A_CTRL, 8'h00);
		wr_reg(`RPFC_A_RESTORE, `RPFC_RESTORE_FACT);
		settle;
		`CHK(nfact, 1)
		tally_and_finish;
	end
endmodule
`default_nettype wire
